// ==== hdl/dpc_pkg.sv ====
// package for the parameter and configuration checker
package dpc_pkg;
  // parameter byte positions
  localparam logic [7:0]  PRM_IDX_CYCLE   = 8'h2B;  // byte 43
  localparam logic [7:0]  PRM_IDX_BGND    = 8'h2C;  // byte 44
  localparam logic [7:0]  PRM_IDX_RET_HI  = 8'h2D;  // byte 45
  localparam logic [7:0]  PRM_IDX_RET_LO  = 8'h2E;  // byte 46
  localparam logic [7:0]  PRM_MIN         = 8'h01;
  localparam logic [9:0]  RET_MAX         = 10'h200;  // 512
  localparam logic [9:0]  RET_MIN         = 10'h001;
  // reset values of the programmed parameters
  localparam logic [7:0]  RST_CYCLE       = 8'h0A;
  localparam logic [7:0]  RST_BGND        = 8'h01;
  localparam logic [9:0]  RST_RET         = 10'h001;
  // identifiers
  localparam logic [7:0]  ID_IFACE        = 8'hB1;
  localparam logic [3:0]  NIB_DIG_IN      = 4'h1;
  localparam logic [3:0]  NIB_DIG_OUT     = 4'h2;
  localparam logic [3:0]  NIB_DIG_IO      = 4'h3;
  localparam logic [3:0]  NIB_ANA_VAL     = 4'h5;  // values only, per channel
  localparam logic [3:0]  NIB_ANA_CHAN    = 4'hB;  // complete channel
  localparam logic [7:0]  ANA_VAL_BYTES   = 8'h02;  // 16-bit user data
  localparam logic [7:0]  ANA_CHAN_BYTES  = 8'h03;  // status byte plus 16 bits
  localparam logic [7:0]  RC_CODE_BIT     = 8'h80;  // register comms code in ctrl/status
  // avalon register map (word addresses)
  localparam logic [3:0]  A_CTRL          = 4'h0;
  localparam logic [3:0]  A_STATUS        = 4'h1;
  localparam logic [3:0]  A_CYCLE         = 4'h2;
  localparam logic [3:0]  A_BGND          = 4'h3;
  localparam logic [3:0]  A_RETAIN        = 4'h4;
  localparam logic [3:0]  A_LEN           = 4'h5;
  localparam logic [3:0]  A_EXPECT        = 4'h6;
  localparam logic [3:0]  A_CFGIN         = 4'h7;
  localparam logic [3:0]  A_PRMIN         = 4'h8;
  localparam logic [3:0]  A_CHSTAT        = 4'h9;
  localparam logic [31:0] UNMAPPED_VAL    = 32'hDEAD_0000;
  // ctrl bits
  localparam int          CB_DIAG         = 0;
  localparam int          CB_FULL_READ    = 1;
  localparam int          CB_START        = 2;
  localparam int          CB_PRM_START    = 3;
  typedef enum logic [1:0] {DPC_ST_IDLE, DPC_ST_ANA, DPC_ST_DIG, DPC_ST_DONE} dpc_state_e;
  typedef struct packed {
    logic       ok;
    logic       bad_order;
    logic       bad_len;
    logic       diag_dropped;
    logic       plc_if;
    logic       diag_if;
    logic       busy;
  } dpc_status_s;
endpackage : dpc_pkg

// ==== hdl/dpc_checker.sv ====
// parameter loader and configuration identifier checker
`timescale 1ns/100ps
// How it works
// - parameter byte 43 is taken as the nominal plc cycle time in ms, valid 1 to 255.
// - parameter byte 44 is taken as the background time in ms, valid 1 to 255.
// - bytes 45 and 46 form the retained flag byte count from the first flag byte, valid 1 to 512.
// - a parameter value not supplied, or out of range, leaves the last programmed value in place.
// - identifier 0xB1 at the head of the list selects the two-byte plc interface.
// - with the diagnostic interface on, the next entry must be 0xB1, or the diagnostic interface is dropped and that entry is taken as a body entry.
// - only terminals assigned to the fieldbus image count toward the expected lengths.
// - digital inputs and outputs each pack into one byte array in slot order.
// - digital identifiers carry n+1 bytes in the low nibble, upper 1 in, 2 out, 3 both.
// - summed digital input and output bytes must equal the rounded-up digital lengths.
// - every digital identifier must follow all analog identifiers; a digital one in the plc or diag id slot lets later analog ids pass.
// - each analog channel carries a status/control byte plus 16 bits of user data.
// - a code in the status/control byte says whether the user data is register traffic.
// - one analog identifier per mapped analog channel is expected, in slot order.
// - a control bit selects value-only or complete-channel readback of the configuration.
module dpc_checker
  import dpc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // terminal map from the bus side
  input  wire logic [7:0]  term_ana_chans,
  input  wire logic [7:0]  term_ana_mapped,
  input  wire logic [11:0] term_din_bits,
  input  wire logic [11:0] term_dout_bits,
  input  wire logic [7:0]  ana_status_byte,
  // results
  output logic             cyclic_enable,
  output logic             reg_comm_active,
  output logic      [7:0]  cfg_readback
);

  // register state
  logic [7:0]  cycle_ms_r, cycle_ms_nxt;
  logic [7:0]  bgnd_ms_r,  bgnd_ms_nxt;
  logic [9:0]  retain_r,   retain_nxt;
  logic [7:0]  ret_hi_r;
  logic [3:0]  ctrl_r;
  logic [7:0]  prm_idx_r;
  logic        waitreq_r;
  logic [31:0] rdata_r;
  dpc_state_e  state_r, state_nxt;
  logic [1:0]  head_r;       // 0 expect plc id, 1 expect diag id, 2 body
  logic [7:0]  ana_seen_r;
  logic [11:0] din_sum_r, dout_sum_r;
  logic        bad_order_r, bad_len_r, drop_r, plc_r, diag_r, ok_r;
  logic        cyc_r, rc_r;
  logic [7:0]  rb_r;
  logic [7:0]  ana_cnt_r;

  // bus decode
  wire         acc       = (avs_read | avs_write) & waitreq_r;
  wire         wr        = avs_write & ~waitreq_r;  // lands on the edge that completes the transfer
  wire         wr_ctrl   = wr && (avs_address == A_CTRL);
  wire         wr_cfg    = wr && (avs_address == A_CFGIN) && state_r != DPC_ST_IDLE && state_r != DPC_ST_DONE;
  wire         wr_prm    = wr && (avs_address == A_PRMIN);
  wire         wr_done   = wr && (avs_address == A_LEN) && state_r != DPC_ST_IDLE;
  wire [7:0]   cfg_byte  = avs_writedata[7:0];
  wire [3:0]   hi_nib    = cfg_byte[7:4];
  wire [11:0]  dig_bytes = {8'h00, cfg_byte[3:0]} + 12'h001;
  wire         is_din    = (hi_nib == NIB_DIG_IN)  || (hi_nib == NIB_DIG_IO);
  wire         is_dout   = (hi_nib == NIB_DIG_OUT) || (hi_nib == NIB_DIG_IO);
  wire         is_dig    = is_din | is_dout;
  wire         is_ana    = (hi_nib == NIB_ANA_VAL) || (hi_nib == NIB_ANA_CHAN);
  // rounded-up byte lengths of the packed digital arrays
  wire [11:0]  din_need  = (term_din_bits  + 12'h007) >> 3;
  wire [11:0]  dout_need = (term_dout_bits + 12'h007) >> 3;
  // unassigned terminals are simply not counted
  wire [7:0]   ana_need  = (term_ana_mapped < term_ana_chans) ? term_ana_mapped : term_ana_chans;
  wire         len_good  = (din_sum_r == din_need) && (dout_sum_r == dout_need)
                           && (ana_seen_r == ana_need);
  wire [7:0]   prm_byte  = avs_writedata[7:0];
  wire [9:0]   ret_word  = {ret_hi_r[1:0], prm_byte};
  wire         ret_ok    = (ret_word >= RET_MIN) && (ret_word <= RET_MAX) && (ret_hi_r[7:2] == 6'h00);
  wire         diag_hit  = (head_r == 2'd1) && (cfg_byte == ID_IFACE);
  wire         diag_miss = (head_r == 2'd1) && (cfg_byte != ID_IFACE);
  wire         plc_hit   = (head_r == 2'd0) && (cfg_byte == ID_IFACE);
  wire         ana_code  = (ana_status_byte & RC_CODE_BIT) != 8'h00;
  dpc_status_s status_w;
  assign status_w = '{ok: ok_r, bad_order: bad_order_r, bad_len: bad_len_r, diag_dropped: drop_r,
                      plc_if: plc_r, diag_if: diag_r, busy: state_r != DPC_ST_IDLE && state_r != DPC_ST_DONE};

  // parameter loading
  always_comb begin
    cycle_ms_nxt = cycle_ms_r;
    bgnd_ms_nxt  = bgnd_ms_r;
    retain_nxt   = retain_r;
    if (wr_prm && prm_idx_r == PRM_IDX_CYCLE && prm_byte >= PRM_MIN) begin
      cycle_ms_nxt = prm_byte;
    end else if (wr_prm && prm_idx_r == PRM_IDX_BGND && prm_byte >= PRM_MIN) begin
      bgnd_ms_nxt = prm_byte;
    end else if (wr_prm && prm_idx_r == PRM_IDX_RET_LO && ret_ok) begin
      retain_nxt = ret_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cycle_ms_r <= RST_CYCLE;
      bgnd_ms_r  <= RST_BGND;
      retain_r   <= RST_RET;
      ret_hi_r   <= 8'h00;
      prm_idx_r  <= 8'h00;
    end else begin
      cycle_ms_r <= cycle_ms_nxt;
      bgnd_ms_r  <= bgnd_ms_nxt;
      retain_r   <= retain_nxt;
      // a new telegram restarts byte counting at zero
      if (wr_ctrl && avs_writedata[CB_PRM_START]) begin
        prm_idx_r <= 8'h00;
      end else if (wr_prm) begin
        prm_idx_r <= prm_idx_r + 8'h01;
      end
      if (wr_prm && prm_idx_r == PRM_IDX_RET_HI) begin
        ret_hi_r <= prm_byte;
      end
    end
  end

  // configuration walk
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DPC_ST_IDLE: begin
        if (wr_ctrl && avs_writedata[CB_START]) begin
          state_nxt = DPC_ST_ANA;
        end
      end
      DPC_ST_ANA: begin
        if (wr_done) begin
          state_nxt = DPC_ST_DONE;
        end else if (wr_cfg && head_r == 2'd2 && is_dig) begin
          state_nxt = DPC_ST_DIG;
        end
      end
      DPC_ST_DIG: begin
        if (wr_done) begin
          state_nxt = DPC_ST_DONE;
        end
      end
      DPC_ST_DONE: begin
        if (wr_ctrl && avs_writedata[CB_START]) begin
          state_nxt = DPC_ST_ANA;
        end
      end
      default: state_nxt = DPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r     <= DPC_ST_IDLE;
      ctrl_r      <= 4'h0;
      head_r      <= 2'd0;
      ana_seen_r  <= 8'h00;
      din_sum_r   <= 12'h000;
      dout_sum_r  <= 12'h000;
      bad_order_r <= 1'b0;
      bad_len_r   <= 1'b0;
      drop_r      <= 1'b0;
      plc_r       <= 1'b0;
      diag_r      <= 1'b0;
      ok_r        <= 1'b0;
      cyc_r       <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[3:0];
      end
      if (wr_ctrl && avs_writedata[CB_START]) begin
        head_r      <= 2'd0;
        ana_seen_r  <= 8'h00;
        din_sum_r   <= 12'h000;
        dout_sum_r  <= 12'h000;
        bad_order_r <= 1'b0;
        bad_len_r   <= 1'b0;
        drop_r      <= 1'b0;
        plc_r       <= 1'b0;
        diag_r      <= 1'b0;
        ok_r        <= 1'b0;
        cyc_r       <= 1'b0;  // no exchange while a new list is checked
      end else if (wr_cfg) begin
        if (plc_hit) begin
          plc_r  <= 1'b1;
          head_r <= ctrl_r[CB_DIAG] ? 2'd1 : 2'd2;
        end else if (diag_hit) begin
          diag_r <= 1'b1;
          head_r <= 2'd2;
        end else begin
          // a missing diagnostic id is dropped, the byte is then taken as a body entry
          drop_r <= drop_r | diag_miss;
          head_r <= 2'd2;
          if (is_ana) begin
            ana_seen_r  <= ana_seen_r + 8'h01;
            bad_order_r <= bad_order_r | (state_r == DPC_ST_DIG);
          end else if (is_dig) begin
            din_sum_r  <= din_sum_r  + (is_din  ? dig_bytes : 12'h000);
            dout_sum_r <= dout_sum_r + (is_dout ? dig_bytes : 12'h000);
          end else begin
            bad_order_r <= 1'b1;
          end
        end
      end else if (wr_done) begin
        bad_len_r <= ~len_good;
        ok_r      <= len_good & ~bad_order_r;
        cyc_r     <= len_good & ~bad_order_r;
      end
    end
  end

  // per-channel readback and register traffic flag
  wire [7:0] chan_bytes = ctrl_r[CB_FULL_READ] ? ANA_CHAN_BYTES : ANA_VAL_BYTES;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rc_r      <= 1'b0;
      rb_r      <= 8'h00;
      ana_cnt_r <= 8'h00;
    end else begin
      rc_r      <= cyc_r & ctrl_r[CB_FULL_READ] & ana_code;
      rb_r      <= ctrl_r[CB_FULL_READ] ? {NIB_ANA_CHAN, 4'h2} : {NIB_ANA_VAL, 4'h0};
      ana_cnt_r <= ana_seen_r;
    end
  end

  // avalon slave: one wait cycle then answer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
    end else begin
      waitreq_r <= ~(acc);
      if (avs_read && waitreq_r) begin
        if (avs_address == A_CTRL) begin
          rdata_r <= {28'h0, ctrl_r};
        end else if (avs_address == A_STATUS) begin
          rdata_r <= {25'h0, status_w};
        end else if (avs_address == A_CYCLE) begin
          rdata_r <= {24'h0, cycle_ms_r};
        end else if (avs_address == A_BGND) begin
          rdata_r <= {24'h0, bgnd_ms_r};
        end else if (avs_address == A_RETAIN) begin
          rdata_r <= {22'h0, retain_r};
        end else if (avs_address == A_LEN) begin
          rdata_r <= {8'h0, dout_sum_r, din_sum_r[7:0], ana_cnt_r[3:0]};
        end else if (avs_address == A_EXPECT) begin
          rdata_r <= {4'h0, dout_need, din_need[7:0], ana_need};
        end else if (avs_address == A_CHSTAT) begin
          rdata_r <= {16'h0, chan_bytes, rb_r};
        end else begin
          rdata_r <= UNMAPPED_VAL;
        end
      end
    end
  end

  assign avs_waitrequest = waitreq_r;
  assign avs_readdata    = rdata_r;
  assign cyclic_enable   = cyc_r;
  assign reg_comm_active = rc_r;
  assign cfg_readback    = rb_r;

  // checks
  property p_prm_hold;
    @(posedge core_clk) disable iff (reset)
      (wr_prm && prm_idx_r == PRM_IDX_CYCLE && prm_byte == 8'h00) |=> $stable(cycle_ms_r);
  endproperty
  a_prm_hold: assert property (p_prm_hold) else $error("zero cycle time was accepted");

  property p_cycle_load;
    @(posedge core_clk) disable iff (reset)
      (wr_prm && prm_idx_r == PRM_IDX_CYCLE && prm_byte != 8'h00) |=> cycle_ms_r == $past(prm_byte);
  endproperty
  a_cycle_load: assert property (p_cycle_load) else $error("cycle time not loaded");

  property p_bgnd_range;
    @(posedge core_clk) disable iff (reset) bgnd_ms_r != 8'h00;
  endproperty
  a_bgnd_range: assert property (p_bgnd_range) else $error("background time left range");

  property p_retain_range;
    @(posedge core_clk) disable iff (reset) retain_r >= RET_MIN && retain_r <= RET_MAX;
  endproperty
  a_retain_range: assert property (p_retain_range) else $error("retained count out of range");

  property p_reject;
    @(posedge core_clk) disable iff (reset) wr_done && !len_good |=> !cyclic_enable && bad_len_r;
  endproperty
  a_reject: assert property (p_reject) else $error("bad list enabled exchange");

  property p_order;
    @(posedge core_clk) disable iff (reset)
      (wr_cfg && state_r == DPC_ST_DIG && is_ana && !plc_hit && !diag_hit) |=> bad_order_r;
  endproperty
  a_order: assert property (p_order) else $error("analog after digital not flagged");

  property p_diag_drop;
    @(posedge core_clk) disable iff (reset) (wr_cfg && diag_miss) |=> drop_r && !diag_r;
  endproperty
  a_diag_drop: assert property (p_diag_drop) else $error("missing diag id not dropped");

  property p_plc;
    @(posedge core_clk) disable iff (reset) (wr_cfg && plc_hit) |=> plc_r ##1 plc_r;
  endproperty
  a_plc: assert property (p_plc) else $error("plc interface not selected");

  property p_wait_one;
    @(posedge core_clk) disable iff (reset) acc |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong");

  property p_cyc_ok;
    @(posedge core_clk) disable iff (reset)
      cyclic_enable |-> ok_r && !bad_len_r && !bad_order_r;
  endproperty
  a_cyc_ok: assert property (p_cyc_ok) else $error("exchange enabled without an accepted list");

  property p_rc_gate;
    @(posedge core_clk) disable iff (reset)
      reg_comm_active |-> $past(cyclic_enable) && $past(ctrl_r[CB_FULL_READ]);
  endproperty
  a_rc_gate: assert property (p_rc_gate) else $error("register traffic flagged without full channels");

  property p_diag_take;
    @(posedge core_clk) disable iff (reset)
      (wr_cfg && diag_hit) |=> diag_r && !drop_r;
  endproperty
  a_diag_take: assert property (p_diag_take) else $error("diag id not taken");

  c_accept: cover property (@(posedge core_clk) disable iff (reset) wr_done && len_good && !bad_order_r);
  c_reject: cover property (@(posedge core_clk) disable iff (reset) wr_done && !len_good);
  c_drop:   cover property (@(posedge core_clk) disable iff (reset) wr_cfg && diag_miss);
  c_full:   cover property (@(posedge core_clk) disable iff (reset) rc_r);
  c_order:  cover property (@(posedge core_clk) disable iff (reset) wr_cfg && is_ana && state_r == DPC_ST_DIG);

endmodule : dpc_checker

// ==== dv/dpc_dp_master.sv ====
// fieldbus master model: parameter and configuration telegrams over avalon
`timescale 1ns/100ps
module dpc_dp_master
  import dpc_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // avalon-mm master side
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // request held until the edge that sees waitrequest low; no cycle count assumed
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_writedata <= ~d;  // stale data never looks valid
  endtask : xfer
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  // bytes 0..42 lie outside this block; out-of-range values only when the bench asks
  task automatic send_prm(input logic [7:0] b43, input logic [7:0] b44, input logic [7:0] b45, input logic [7:0] b46);
    wr(A_CTRL, 32'h0000_0008);
    for (int i = 0; i < 43; i++) begin
      wr(A_PRMIN, 32'h0000_0000);
    end
    wr(A_PRMIN, {24'h000000, b43});
    wr(A_PRMIN, {24'h000000, b44});
    wr(A_PRMIN, {24'h000000, b45});
    wr(A_PRMIN, {24'h000000, b46});
  endtask : send_prm
  // ctl bit0 diag on, bit1 full readback; ids sent from the top byte down
  task automatic send_cfg(input logic [1:0] ctl, input logic [2:0] n, input logic [5:0][7:0] ids);
    wr(A_CTRL, {28'h0000000, 2'b01, ctl});
    for (int i = 0; i < n; i++) begin
      wr(A_CFGIN, {24'h000000, ids[5-i]});
    end
    wr(A_LEN, 32'h0000_0000);
  endtask : send_cfg
endmodule : dpc_dp_master

// ==== dv/dp_slave_param_cfg_checker_test.sv ====
// self-checking bench for the parameter and configuration checker
`timescale 1ns/100ps
module dp_slave_param_cfg_checker_test
  import dpc_pkg::*;
;
  typedef struct packed {
    logic            diag;
    logic [2:0]      n;
    logic [5:0][7:0] ids;
    logic [7:0]      ch;
    logic [7:0]      mp;
    logic [11:0]     di;
    logic [11:0]     dq;
    logic            ok;
    logic            dd;
  } dpc_row_s;
  logic        core_clk;
  logic        reset;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  term_ana_chans;
  logic [7:0]  term_ana_mapped;
  logic [11:0] term_din_bits;
  logic [11:0] term_dout_bits;
  logic [7:0]  ana_status_byte;
  logic        cyclic_enable;
  logic        reg_comm_active;
  logic [7:0]  cfg_readback;
  int          mismatches;
  int          checked;
  dpc_row_s    rows [10];
  logic [31:0] q;

  dpc_checker DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .term_ana_chans(term_ana_chans), .term_ana_mapped(term_ana_mapped),
    .term_din_bits(term_din_bits), .term_dout_bits(term_dout_bits), .ana_status_byte(ana_status_byte),
    .cyclic_enable(cyclic_enable), .reg_comm_active(reg_comm_active), .cfg_readback(cfg_readback));
  dpc_dp_master MST (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_prm(input logic [7:0] c, input logic [7:0] b, input logic [9:0] r);
    MST.xfer(1'b0, A_CYCLE, 32'h0000_0000, q);
    chk(q, {24'h000000, c});
    MST.xfer(1'b0, A_BGND, 32'h0000_0000, q);
    chk(q, {24'h000000, b});
    MST.xfer(1'b0, A_RETAIN, 32'h0000_0000, q);
    chk(q, {22'h000000, r});
  endtask : chk_prm
  task automatic set_terms(input dpc_row_s r);
    @(posedge core_clk);
    term_ana_chans  <= r.ch;
    term_ana_mapped <= r.mp;
    term_din_bits   <= r.di;
    term_dout_bits  <= r.dq;
  endtask : set_terms

  // watchdog well beyond the expected several hundred cycles
  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    reset           = 1'b1;
    term_ana_chans  = 8'h01;
    term_ana_mapped = 8'h01;
    term_din_bits   = 12'h00C;
    term_dout_bits  = 12'h008;
    ana_status_byte = 8'h00;
    rows[0] = '{1'b0, 3'h4, {8'hB1, 8'h50, 8'h11, 8'h20, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b1, 1'b0};
    rows[1] = '{1'b0, 3'h4, {8'hB1, 8'h11, 8'h20, 8'h50, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b0, 1'b0};
    rows[2] = '{1'b0, 3'h4, {8'hB1, 8'h50, 8'h10, 8'h20, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b0, 1'b0};
    rows[3] = '{1'b0, 3'h3, {8'hB1, 8'h50, 8'h30, 8'h00, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h008, 12'h008, 1'b1, 1'b0};
    rows[4] = '{1'b0, 3'h4, {8'hB1, 8'h50, 8'h11, 8'h20, 8'h00, 8'h00}, 8'h02, 8'h01, 12'h00C, 12'h008, 1'b1, 1'b0};
    rows[5] = '{1'b0, 3'h5, {8'hB1, 8'h50, 8'h50, 8'h11, 8'h20, 8'h00}, 8'h02, 8'h01, 12'h00C, 12'h008, 1'b0, 1'b0};
    rows[6] = '{1'b0, 3'h4, {8'hB1, 8'hB2, 8'h11, 8'h20, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b1, 1'b0};
    rows[7] = '{1'b1, 3'h5, {8'hB1, 8'hB1, 8'h50, 8'h11, 8'h20, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b1, 1'b0};
    rows[8] = '{1'b1, 3'h4, {8'hB1, 8'h50, 8'h11, 8'h20, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h008, 1'b1, 1'b1};
    rows[9] = '{1'b0, 3'h4, {8'hB1, 8'h50, 8'h11, 8'h22, 8'h00, 8'h00}, 8'h01, 8'h01, 12'h00C, 12'h011, 1'b1, 1'b0};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, cyclic_enable}, 32'h0000_0000);
    chk({24'h000000, cfg_readback}, 32'h0000_0050);
    chk_prm(RST_CYCLE, RST_BGND, RST_RET);
    // boundary values 255 and 512 are accepted
    MST.send_prm(8'hFF, 8'h01, 8'h02, 8'h00);
    chk_prm(8'hFF, 8'h01, 10'h200);
    // zero and 513 are refused, last programmed values stay
    MST.send_prm(8'h00, 8'h00, 8'h02, 8'h01);
    chk_prm(8'hFF, 8'h01, 10'h200);
    for (int i = 0; i < 10; i++) begin
      set_terms(rows[i]);
      MST.send_cfg({1'b0, rows[i].diag}, rows[i].n, rows[i].ids);
      repeat (2) @(posedge core_clk);
      chk({31'h0, cyclic_enable}, {31'h0, rows[i].ok});
      MST.xfer(1'b0, A_STATUS, 32'h0000_0000, q);
      // ok sits in bit 6 and the dropped flag in bit 3 of the status word
      chk(q & 32'h0000_0048, {25'h0, rows[i].ok, 2'b00, rows[i].dd, 3'b000});
    end
    // complete-channel readback and register traffic flag
    set_terms(rows[6]);
    MST.send_cfg(2'b10, rows[6].n, rows[6].ids);
    repeat (2) @(posedge core_clk);
    chk({24'h000000, cfg_readback}, 32'h0000_00B2);
    MST.xfer(1'b0, A_CHSTAT, 32'h0000_0000, q);
    chk(q, {16'h0000, ANA_CHAN_BYTES, 8'hB2});
    ana_status_byte <= 8'h80;
    repeat (3) @(posedge core_clk);
    chk({31'h0, reg_comm_active}, 32'h0000_0001);
    ana_status_byte <= 8'h00;
    repeat (3) @(posedge core_clk);
    chk({31'h0, reg_comm_active}, 32'h0000_0000);
    MST.xfer(1'b0, 4'hF, 32'h0000_0000, q);
    chk(q, UNMAPPED_VAL);
    // second reset in mid-run drops the accepted list and parameters
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, cyclic_enable}, 32'h0000_0000);
    chk_prm(RST_CYCLE, RST_BGND, RST_RET);
    final_report();
  end
endmodule : dp_slave_param_cfg_checker_test
